//--- verilog/nhc_regs.svh
/*
 * Register offsets, field positions, reset values, command codes and
 * timing figures of the NAND host controller.
 * Assumes a 200 MHz system clock and 32-bit APB data.
 */
`ifndef NHC_REGS_SVH
`define NHC_REGS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define NHC_OFF_CYCLE 12'h000
`define NHC_OFF_STATUS 12'h004
`define NHC_OFF_RDATA 12'h008
`define NHC_OFF_CONFIG 12'h00C

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define NHC_CYC_DATA_LSB 0
`define NHC_CYC_DATA_MSB 7
`define NHC_CYC_KIND_LSB 8
`define NHC_CYC_KIND_MSB 9
`define NHC_ST_BUSY 0
`define NHC_ST_RB 1
`define NHC_ST_RST_DONE 2
`define NHC_ST_ERR 3
`define NHC_CF_WP_N 0
`define NHC_CF_CE_N 1
`define NHC_CF_LOCK 2
`define NHC_CF_ECC_ON 3

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define NHC_CF_RESET 4'h2

// -----------------------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------------------
`define NHC_CMD_RESET 8'hFF
`define NHC_CMD_STATUS 8'h70
`define NHC_CMD_STATUS_ENH 8'h78
`define NHC_CMD_READ 8'h00
`define NHC_CMD_MOVE_PROG 8'h85
`define NHC_CMD_TWO_PLANE_A 8'h11
`define NHC_CMD_TWO_PLANE_B 8'h32

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define NHC_CLK_PERIOD_NS 5
`define NHC_T_SETUP_NS 10
`define NHC_T_WP_NS 15
`define NHC_T_WH_NS 10
`define NHC_T_REA_NS 20
`define NHC_SYNC_CYC 2
`define NHC_CEIL_CYC(ns) (((ns) + `NHC_CLK_PERIOD_NS - 1) / `NHC_CLK_PERIOD_NS)

`endif

//--- verilog/nhc_pkg.sv
/*
 * Types of the NAND host controller.
 * Assumes nothing of its surroundings.
 */
package nhc_pkg;

    typedef enum logic [1:0] {
        NHC_K_CMD = 2'h0,
        NHC_K_ADDR = 2'h1,
        NHC_K_WDAT = 2'h2,
        NHC_K_RDAT = 2'h3
    } nhc_kind_t;

    typedef enum logic [1:0] {
        NHC_S_IDLE = 2'h0,
        NHC_S_SETUP = 2'h1,
        NHC_S_LOW = 2'h2,
        NHC_S_HIGH = 2'h3
    } nhc_state_t;

endpackage : nhc_pkg

//--- verilog/nhc_cyc_if.sv
/*
 * Request and answer of one bus cycle between controller and sequencer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface nhc_cyc_if;
    import nhc_pkg::*;
    logic start;
    nhc_kind_t kind;
    logic [7:0] wdata;
    logic busy;
    logic done;
    logic [7:0] rdata;
    modport ctrl(output start, output kind, output wdata, input busy, input done, input rdata);
    modport seq(input start, input kind, input wdata, output busy, output done, output rdata);
endinterface : nhc_cyc_if

//--- verilog/nhc_seq.sv
/*
 * Bus-cycle sequencer: turns one request into one strobe cycle on the pins.
 * Assumes start is only raised while busy is low.
 */
`timescale 1ns/1ps
`include "nhc_regs.svh"
module nhc_seq (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    nhc_cyc_if.seq cyc,
    input wire logic [7:0] i_io_in,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_re_n,
    output logic [7:0] o_io_out,
    output logic o_io_oe
);
    import nhc_pkg::*;

    localparam logic [3:0] SETUP_CYC = 4'(`NHC_CEIL_CYC(`NHC_T_SETUP_NS));
    localparam logic [3:0] WP_CYC = 4'(`NHC_CEIL_CYC(`NHC_T_WP_NS));
    localparam logic [3:0] WH_CYC = 4'(`NHC_CEIL_CYC(`NHC_T_WH_NS));
    // Read data passes the two-flop synchroniser, so the strobe stays low longer.
    localparam logic [3:0] RP_CYC = 4'(`NHC_CEIL_CYC(`NHC_T_REA_NS) + `NHC_SYNC_CYC);

    nhc_state_t state_q;
    nhc_kind_t kind_q;
    logic [3:0] cnt_q;
    logic [7:0] io_s1_q;
    logic [7:0] io_s2_q;
    logic [7:0] rdata_q;
    logic done_q;
    logic cnt_zero;
    logic is_read;

    assign cnt_zero = (cnt_q == 4'h0);
    assign is_read = (kind_q == NHC_K_RDAT);
    assign cyc.busy = (state_q != NHC_S_IDLE);
    assign cyc.done = done_q;
    assign cyc.rdata = rdata_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
        end else begin
            io_s1_q <= i_io_in;
            io_s2_q <= io_s1_q;
        end
    end

    // -------------------------------------------------------------------------
    // Strobe cycle
    // -------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= NHC_S_IDLE;
            kind_q <= NHC_K_CMD;
            cnt_q <= 4'h0;
            rdata_q <= 8'h00;
            done_q <= 1'b0;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_re_n <= 1'b1;
            o_io_out <= 8'h00;
            o_io_oe <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                NHC_S_IDLE: begin
                    if (cyc.start) begin
                        kind_q <= cyc.kind;
                        o_cle <= (cyc.kind == NHC_K_CMD);
                        o_ale <= (cyc.kind == NHC_K_ADDR);
                        o_io_out <= cyc.wdata;
                        o_io_oe <= (cyc.kind != NHC_K_RDAT);
                        cnt_q <= SETUP_CYC - 4'h1;
                        state_q <= NHC_S_SETUP;
                    end
                end
                NHC_S_SETUP: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        o_we_n <= is_read;
                        o_re_n <= !is_read;
                        cnt_q <= (is_read ? RP_CYC : WP_CYC) - 4'h1;
                        state_q <= NHC_S_LOW;
                    end
                end
                NHC_S_LOW: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        o_we_n <= 1'b1;
                        o_re_n <= 1'b1;
                        if (is_read) begin
                            rdata_q <= io_s2_q;
                        end
                        cnt_q <= WH_CYC - 4'h1;
                        state_q <= NHC_S_HIGH;
                    end
                end
                NHC_S_HIGH: begin
                    cnt_q <= cnt_q - 4'h1;
                    if (cnt_zero) begin
                        o_cle <= 1'b0;
                        o_ale <= 1'b0;
                        o_io_oe <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= NHC_S_IDLE;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    sequence s_we_pulse;
        !o_we_n [*3] ##1 o_we_n;
    endsequence

    sequence s_re_pulse;
        !o_re_n [*6] ##1 o_re_n;
    endsequence

    a_we_pulse_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(o_we_n) |-> s_we_pulse)
        else $error("write strobe low time wrong");

    a_re_pulse_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $fell(o_re_n) |-> s_re_pulse)
        else $error("read strobe low time wrong");

    a_latch_one_kind: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_we_n |-> !(o_cle && o_ale) && o_io_oe)
        else $error("write strobe low with both latches or bus undriven");

    a_cmd_latch_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_we_n) && kind_q == NHC_K_CMD |-> o_cle && !o_ale)
        else $error("command strobe edge without command latch");

    a_addr_latch_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_we_n) && kind_q == NHC_K_ADDR |-> o_ale && !o_cle)
        else $error("address strobe edge without address latch");

    a_read_no_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !o_re_n |-> !o_io_oe && o_we_n)
        else $error("bus driven during read strobe");

    a_cycle_done: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        cyc.start && !cyc.busy |-> ##[8:12] done_q)
        else $error("bus cycle did not finish in time");

endmodule : nhc_seq

//--- verilog/nhc_host.sv
/*
 * NAND host controller: APB register slave that drives an asynchronous
 * 8-bit NAND flash bus one cycle at a time and guards the command order.
 * Assumes a 200 MHz clock, pins synchronised here, and a pull-up on ready/busy.
 */
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "nhc_regs.svh"
module nhc_host (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_ce_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_re_n,
    output logic [7:0] o_io_out,
    output logic o_io_oe,
    input wire logic [7:0] i_io_in,
    output logic o_wp_n,
    output logic o_lock,
    input wire logic i_rb_n
);
    import nhc_pkg::*;

    nhc_cyc_if cyc ();

    nhc_seq u_seq (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .cyc(cyc.seq),
        .i_io_in(i_io_in),
        .o_cle(o_cle),
        .o_ale(o_ale),
        .o_we_n(o_we_n),
        .o_re_n(o_re_n),
        .o_io_out(o_io_out),
        .o_io_oe(o_io_oe)
    );

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic rb_s1_q;
    logic rb_s2_q;
    logic [3:0] cfg_q;
    logic err_q;
    logic rst_done_q;
    logic [7:0] rdata_q;
    logic [7:0] last_cmd_q;
    logic [7:0] prev_addr_q;
    logic [2:0] addr_idx_q;
    logic read_plane_q;
    logic start_q;
    nhc_kind_t kind_q;
    logic [7:0] wdata_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // -------------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------------
    logic access;
    logic commit;
    logic wr_commit;
    logic sel_cycle;
    logic sel_status;
    logic sel_rdata;
    logic sel_config;
    logic mapped;
    logic cycle_clash;
    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign access = i_psel && i_penable && !pready_q;
    // A write takes effect only at the edge where the master sees pready high.
    assign commit = i_psel && i_penable && pready_q;
    assign wr_commit = commit && i_pwrite && !pslverr_q;
    assign sel_cycle = (i_paddr == `NHC_OFF_CYCLE);
    assign sel_status = (i_paddr == `NHC_OFF_STATUS);
    assign sel_rdata = (i_paddr == `NHC_OFF_RDATA);
    assign sel_config = (i_paddr == `NHC_OFF_CONFIG);
    assign mapped = sel_cycle || sel_status || sel_rdata || sel_config;
    assign cycle_clash = sel_cycle && i_pwrite && (cyc.busy || start_q);

    assign status_word = {28'h000_0000, err_q, rst_done_q, rb_s2_q, cyc.busy || start_q};
    assign rd_mux = sel_status ? status_word :
                    sel_rdata ? {24'h00_0000, rdata_q} :
                    sel_config ? {28'h000_0000, cfg_q} : 32'h0000_0000;

    // -------------------------------------------------------------------------
    // Cycle request checks
    // -------------------------------------------------------------------------
    logic [7:0] req_data;
    nhc_kind_t req_kind;
    logic req_cmd;
    logic req_addr;
    logic cmd_safe_busy;
    logic cmd_two_plane;
    logic bad_order;
    logic bad_busy;
    logic bad_plane_cmd;
    logic bad_column;
    logic bad_move_plane;
    logic refuse;
    logic go;

    assign req_data = i_pwdata[`NHC_CYC_DATA_MSB:`NHC_CYC_DATA_LSB];
    assign req_kind = nhc_kind_t'(i_pwdata[`NHC_CYC_KIND_MSB:`NHC_CYC_KIND_LSB]);
    assign req_cmd = (req_kind == NHC_K_CMD);
    assign req_addr = (req_kind == NHC_K_ADDR);
    assign cmd_safe_busy = (req_data == `NHC_CMD_RESET) || (req_data == `NHC_CMD_STATUS) ||
                           (req_data == `NHC_CMD_STATUS_ENH);
    assign cmd_two_plane = (req_data == `NHC_CMD_TWO_PLANE_A) || (req_data == `NHC_CMD_TWO_PLANE_B);
    assign bad_order = req_cmd && !rst_done_q && (req_data != `NHC_CMD_RESET);
    assign bad_busy = req_cmd && !rb_s2_q && !cmd_safe_busy;
    assign bad_plane_cmd = req_cmd && cfg_q[`NHC_CF_ECC_ON] && cmd_two_plane;
    // Second address cycle: CA11 is bit 3, CA10:8 are bits 2:0, CA7 was bit 7 of the first.
    assign bad_column = req_addr && (addr_idx_q == 3'h1) && req_data[3] &&
                        (prev_addr_q[7] || (req_data[2:0] != 3'h0) || (req_data[7:4] != 4'h0));
    assign bad_move_plane = req_addr && (addr_idx_q == 3'h2) && (last_cmd_q == `NHC_CMD_MOVE_PROG) &&
                            (req_data[6] != read_plane_q);
    assign refuse = bad_order || bad_busy || bad_plane_cmd || bad_column || bad_move_plane;
    assign go = wr_commit && sel_cycle && !refuse;

    // -------------------------------------------------------------------------
    // APB answer: one wait state, data and error from flops
    // -------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access && (!mapped || cycle_clash || (i_pwrite && sel_rdata));
            prdata_q <= (access && !i_pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // -------------------------------------------------------------------------
    // Pin synchroniser and configuration
    // -------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            cfg_q <= `NHC_CF_RESET;
        end else begin
            rb_s1_q <= i_rb_n;
            rb_s2_q <= rb_s1_q;
            if (wr_commit && sel_config) begin
                cfg_q <= i_pwdata[3:0];
            end
        end
    end

    // -------------------------------------------------------------------------
    // Error flag, reset tracking and read data
    // -------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_q <= 1'b0;
            rst_done_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            if (wr_commit && sel_cycle && refuse) begin
                err_q <= 1'b1;
            end else if (wr_commit && sel_status && i_pwdata[`NHC_ST_ERR]) begin
                err_q <= 1'b0;
            end
            if (go && req_cmd && req_data == `NHC_CMD_RESET) begin
                rst_done_q <= 1'b1;
            end
            if (cyc.done && kind_q == NHC_K_RDAT) begin
                rdata_q <= cyc.rdata;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Address cycle tracking and request to the sequencer
    // -------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_cmd_q <= 8'h00;
            prev_addr_q <= 8'h00;
            addr_idx_q <= 3'h0;
            read_plane_q <= 1'b0;
            start_q <= 1'b0;
            kind_q <= NHC_K_CMD;
            wdata_q <= 8'h00;
        end else begin
            start_q <= go;
            if (go) begin
                kind_q <= req_kind;
                wdata_q <= req_data;
                if (req_cmd) begin
                    last_cmd_q <= req_data;
                    addr_idx_q <= 3'h0;
                end else if (req_addr) begin
                    prev_addr_q <= req_data;
                    if (addr_idx_q != 3'h7) begin
                        addr_idx_q <= addr_idx_q + 3'h1;
                    end
                    if (addr_idx_q == 3'h2 && last_cmd_q == `NHC_CMD_READ) begin
                        read_plane_q <= req_data[6];
                    end
                end
            end
        end
    end

    assign cyc.start = start_q;
    assign cyc.kind = kind_q;
    assign cyc.wdata = wdata_q;

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_ce_n = cfg_q[`NHC_CF_CE_N];
    assign o_wp_n = cfg_q[`NHC_CF_WP_N];
    assign o_lock = cfg_q[`NHC_CF_LOCK];

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    a_reset_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        cyc.start && kind_q == NHC_K_CMD |-> rst_done_q && $past(rst_done_q) || wdata_q == `NHC_CMD_RESET)
        else $error("command sent before reset command");

    a_busy_cmd_only: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        go && req_cmd && !rb_s2_q |->
        ##1 (wdata_q == `NHC_CMD_RESET || wdata_q == `NHC_CMD_STATUS || wdata_q == `NHC_CMD_STATUS_ENH))
        else $error("array command sent to busy die");

    a_ecc_two_plane: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        cyc.start && kind_q == NHC_K_CMD && cfg_q[`NHC_CF_ECC_ON] |->
        wdata_q != `NHC_CMD_TWO_PLANE_A && wdata_q != `NHC_CMD_TWO_PLANE_B)
        else $error("two-plane command with error correction on");

    a_refuse_flags: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_commit && sel_cycle && refuse |=> err_q && !start_q)
        else $error("refused cycle was sent or not flagged");

    a_wp_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        wr_commit && sel_config |=> o_wp_n == $past(i_pwdata[0]))
        else $error("write protect pin did not follow configuration");

endmodule : nhc_host

//--- verification/nhc_dev_model.sv
/*
 * Behavioural flash device on the far side of the host controller.
 * Assumes the bench resolves the shared bus and pulls ready/busy up.
 */
`timescale 1ns/1ps
module nhc_dev_model (
    input wire logic i_ce_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_we_n,
    input wire logic i_re_n,
    input wire logic [7:0] i_io,
    output logic [7:0] o_io,
    output logic o_rb_n
);
    logic [7:0] cmd_q = 8'hEE;
    logic [7:0] addr_q = 8'h00;
    logic [11:0] col_q = 12'h000;
    logic [7:0] abyte_q [5];
    logic [2:0] acnt_q = 3'h0;
    // A die under a raised chip enable drops to standby only while it is ready.
    wire logic standby = i_ce_n && o_rb_n;
    wire logic [16:0] row = {abyte_q[4][0], abyte_q[3], abyte_q[2]};
    wire logic plane = abyte_q[2][6];
    wire logic lock_zone = ({abyte_q[4][0], abyte_q[3], abyte_q[2][7:6]} < 11'h030);
    initial o_rb_n = 1'b1;
    initial o_io = 8'h00;
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_cle) begin
            cmd_q = i_io;
            acnt_q = 3'h0;
            if (i_io == 8'h30) begin
                o_rb_n = 1'b0;
                o_rb_n <= #400 1'b1;
            end
        end else if (!i_ce_n && i_ale) begin
            addr_q = i_io;
            col_q = 12'h000;
            if (acnt_q < 3'h5) begin
                abyte_q[acnt_q] = i_io;
                acnt_q = acnt_q + 3'h1;
            end
        end
    end
    // A released bus shows the inverse of the last byte, never a stale copy.
    always @(negedge i_re_n) begin
        if (!i_ce_n) begin
            o_io = 8'h5A + col_q[7:0];
            col_q = (col_q == 12'h87F) ? 12'h000 : col_q + 12'h001;
        end
    end
    always @(posedge i_re_n) o_io = ~o_io;
endmodule : nhc_dev_model

//--- verification/tb_nhc_host.sv
/*
 * Self-checking bench of the NAND host controller over APB.
 * Assumes the device model beside it and a pull-up on ready/busy.
 */
`timescale 1ns/1ps
`include "nhc_regs.svh"
module tb_nhc_host;
    import nhc_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, ce_n, cle, ale, we_n, re_n, io_oe, wp_n, lock, rb_n, e;
    logic [7:0] io_out, dev_io, b;
    logic [7:0] ab [5];
    wire logic [7:0] bus = io_oe ? io_out : dev_io;
    int error_cnt = 0, num_checks = 0;
    nhc_host u_nhc_host (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_re_n(re_n),
        .o_io_out(io_out), .o_io_oe(io_oe), .i_io_in(bus), .o_wp_n(wp_n), .o_lock(lock), .i_rb_n(rb_n));
    nhc_dev_model u_nhc_dev_model (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
        .i_re_n(re_n), .i_io(bus), .o_io(dev_io), .o_rb_n(rb_n));
    initial forever #2.5 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    function automatic logic [31:0] stat(input logic rst, input logic er);
        return {28'h000_0000, er, rst, 1'b1, 1'b0};
    endfunction : stat
    function automatic logic [16:0] row_of(input logic [7:0] a2, input logic [7:0] a3, input logic [7:0] a4);
        return {a4[0], a3, a2};
    endfunction : row_of
    // One pin cycle, then the error flag compared, and cleared only when it is expected set.
    task automatic cyc(input nhc_kind_t k, input logic [7:0] d, input logic er);
        apb(1'b1, `NHC_OFF_CYCLE, {22'h00_0000, k, d});
        do apb(1'b0, `NHC_OFF_STATUS, 32'h0); while (r[`NHC_ST_BUSY] !== 1'b0);
        chk("status_err", r[`NHC_ST_ERR], er);
        if (er) apb(1'b1, `NHC_OFF_STATUS, 32'h0000_0008);
    endtask : cyc
    initial begin
        #200_000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        void'($urandom(40));
        repeat (2) @(posedge mclk);
        chk("ce_n", ce_n, 1'b1);
        chk("standby", u_nhc_dev_model.standby, 1'b1);
        chk("wp_n", wp_n, 1'b0);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, `NHC_OFF_CONFIG, 32'h0);
        chk("config", r, 32'h0000_0002);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", e, 1'b1);
        apb(1'b1, `NHC_OFF_RDATA, 32'h0);
        chk("rdata_write", e, 1'b1);
        apb(1'b1, `NHC_OFF_CONFIG, 32'h0000_0005);
        chk("lock", lock, 1'b1);
        $display("test reset done");
        cyc(NHC_K_CMD, 8'h00, 1'b1);
        chk("dev_cmd", u_nhc_dev_model.cmd_q, 8'hEE);
        cyc(NHC_K_CMD, `NHC_CMD_RESET, 1'b0);
        chk("dev_cmd", u_nhc_dev_model.cmd_q, 8'hFF);
        $display("test order done");
        cyc(NHC_K_CMD, `NHC_CMD_READ, 1'b0);
        for (int i = 0; i < 5; i++) begin
            b = $urandom();
            if (i == 1) b = b & 8'h07;
            ab[i] = b;
            cyc(NHC_K_ADDR, b, 1'b0);
            chk("dev_addr", u_nhc_dev_model.addr_q, b);
        end
        chk("row", u_nhc_dev_model.row, row_of(ab[2], ab[3], ab[4]));
        chk("plane", u_nhc_dev_model.plane, ab[2][6]);
        chk("lock_zone", u_nhc_dev_model.lock_zone, {ab[4][0], ab[3], ab[2][7:6]} < 11'h030);
        cyc(NHC_K_CMD, 8'h30, 1'b0);
        apb(1'b1, `NHC_OFF_CONFIG, 32'h0000_0007);
        chk("standby", u_nhc_dev_model.standby, 1'b0);
        apb(1'b1, `NHC_OFF_CONFIG, 32'h0000_0005);
        cyc(NHC_K_CMD, `NHC_CMD_READ, 1'b1);
        cyc(NHC_K_CMD, `NHC_CMD_STATUS, 1'b0);
        chk("status_rb", r, {28'h000_0000, 4'h4});
        repeat (100) @(posedge mclk);
        apb(1'b0, `NHC_OFF_STATUS, 32'h0);
        chk("status_rb", r, stat(1'b1, 1'b0));
        for (int i = 0; i < 2 + $urandom_range(2); i++) begin
            cyc(NHC_K_RDAT, 8'h00, 1'b0);
            apb(1'b0, `NHC_OFF_RDATA, 32'h0);
            chk("rdata", r, 32'h0000_005A + i);
        end
        $display("test read done");
        cyc(NHC_K_CMD, `NHC_CMD_READ, 1'b0);
        cyc(NHC_K_ADDR, 8'h80, 1'b0);
        cyc(NHC_K_ADDR, 8'h08, 1'b1);
        apb(1'b1, `NHC_OFF_CONFIG, 32'h0000_000D);
        cyc(NHC_K_CMD, `NHC_CMD_TWO_PLANE_A, 1'b1);
        apb(1'b1, `NHC_OFF_CONFIG, 32'h0000_0005);
        cyc(NHC_K_CMD, `NHC_CMD_TWO_PLANE_B, 1'b0);
        $display("test refusal done");
        cyc(NHC_K_CMD, `NHC_CMD_READ, 1'b0);
        for (int i = 0; i < 3; i++) cyc(NHC_K_ADDR, (i == 2) ? 8'h40 : 8'h00, 1'b0);
        cyc(NHC_K_CMD, `NHC_CMD_MOVE_PROG, 1'b0);
        for (int i = 0; i < 2; i++) cyc(NHC_K_ADDR, 8'h00, 1'b0);
        cyc(NHC_K_ADDR, 8'h00, 1'b1);
        $display("test plane done");
        report_and_stop();
    end
endmodule : tb_nhc_host
